//--- hdl/io_port_pkg.sv
// Package: register map, field positions and carrier structs for the I/O port block
package io_port_pkg;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [7:0] IO_SPACE_LAST = 8'h3f;
  localparam logic [7:0] DATA_SPACE_BIAS = 8'h20;
  localparam logic [7:0] EXT_IO_FIRST = 8'h60;
  localparam logic [7:0] OFS_PORT_B_PIN_LEVEL = 8'h16;
  localparam logic [7:0] OFS_PORT_B_DIRECTION = 8'h17;
  localparam logic [7:0] OFS_PORT_B_OUTPUT_LATCH = 8'h18;
  localparam logic [7:0] OFS_PORT_A_PIN_LEVEL = 8'h19;
  localparam logic [7:0] OFS_PORT_A_DIRECTION = 8'h1a;
  localparam logic [7:0] OFS_PORT_A_OUTPUT_LATCH = 8'h1b;
  localparam logic [7:0] OFS_SPECIAL_FUNCTION_CONTROL = 8'h20;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int PULL_DISABLE_BIT = 2;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] SFC_RESET = 8'h00;
  localparam int PG_WR_BIT = 0;
  localparam int PG_RD_BIT = 1;
  localparam int PG_ALE_BIT = 2;
  localparam int PG_XOUT_BIT = 3;
  localparam int PG_XIN_BIT = 4;
  localparam int PG_WIDTH = 5;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic io_rd;
    logic io_wr;
    logic data_load_op;
    logic mem_save_op;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic ale;
    logic rd_strobe;
    logic wr_strobe;
  } ext_mem_s;

endpackage : io_port_pkg

//--- hdl/io_port_override_logic.sv
// Design: Port A/B general I/O plus Port G override logic
// Functional notes
// - Async select frees PG3 as oscillator output
// - Async select frees PG4 as oscillator input
// - Memory enable forces PG2..0 outputs, no pull-up
// - PG2 latch, PG1 read, PG0 write strobes
// - Global disable bit kills every pull-up
// - I/O instructions decode offsets 0x00..0x3F only
// - Data space address is I/O offset plus 0x20
// - Extended region (0x60 and up) reachable by neither access type
// - Control register at data 0x40, resets zero
// - Port A latch eight bits, reset zero
// - Port A direction eight bits, reset input
// - Port A pin level read only
// - Port B latch eight bits, reset zero
// - Port B direction eight bits, reset zero
// - Port B pin level read only, live
module io_port_override_logic (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire io_port_pkg::reg_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_pullup,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [7:0] pb_pullup,
  input wire logic async_osc_select,
  input wire logic ext_mem_enable,
  input wire io_port_pkg::ext_mem_s ext_mem,
  input wire logic [io_port_pkg::PG_WIDTH-1:0] pg_latch,
  input wire logic [io_port_pkg::PG_WIDTH-1:0] pg_direction,
  input wire logic [io_port_pkg::PG_WIDTH-1:0] pg_in,
  output logic [io_port_pkg::PG_WIDTH-1:0] pg_out,
  output logic [io_port_pkg::PG_WIDTH-1:0] pg_oe,
  output logic [io_port_pkg::PG_WIDTH-1:0] pg_pullup,
  output logic [io_port_pkg::PG_WIDTH-1:0] pg_input_gate,
  output logic [io_port_pkg::PG_WIDTH-1:0] pg_in_sync,
  output logic osc_pins_attached
);
  import io_port_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0] port_a_output_latch_r;
  logic [7:0] port_a_direction_r;
  logic [7:0] port_b_output_latch_r;
  logic [7:0] port_b_direction_r;
  logic [7:0] special_function_control_r;
  logic [7:0] pa_sync_r;
  logic [7:0] pb_sync_r;
  logic [PG_WIDTH-1:0] pg_meta_r;
  logic pullup_global_disable;
  logic [7:0] io_ofs;
  logic hit, acc_wr, acc_rd;

  // Address decode: both instruction classes fold onto one I/O offset
  always_comb begin
    io_ofs = 8'h00;
    hit = 1'b0;
    if (req.io_rd || req.io_wr) begin
      io_ofs = req.addr;
      hit = (req.addr <= IO_SPACE_LAST);
    end else if (req.data_load_op || req.mem_save_op) begin
      io_ofs = req.addr - DATA_SPACE_BIAS;
      // Extended region lies above our window; I/O opcodes never see it
      hit = (req.addr >= DATA_SPACE_BIAS) && (req.addr < EXT_IO_FIRST);
    end
    acc_wr = hit && (req.io_wr || req.mem_save_op);
    acc_rd = hit && (req.io_rd || req.data_load_op);
  end

  // One global bit gates every pull-up of every port
  assign pullup_global_disable = special_function_control_r[PULL_DISABLE_BIT];

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  // Port A latch and direction
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      port_a_output_latch_r <= PORT_RESET;
      port_a_direction_r <= PORT_RESET;
    end else if (acc_wr) begin
      if (io_ofs == OFS_PORT_A_OUTPUT_LATCH) port_a_output_latch_r <= req.wdata;
      if (io_ofs == OFS_PORT_A_DIRECTION) port_a_direction_r <= req.wdata;
    end
  end

  // Port B latch and direction
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      port_b_output_latch_r <= PORT_RESET;
      port_b_direction_r <= PORT_RESET;
    end else if (acc_wr) begin
      if (io_ofs == OFS_PORT_B_OUTPUT_LATCH) port_b_output_latch_r <= req.wdata;
      if (io_ofs == OFS_PORT_B_DIRECTION) port_b_direction_r <= req.wdata;
    end
  end

  // Control register; only the pull-up disable bit is held here
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      special_function_control_r <= SFC_RESET;
    end else if (acc_wr && io_ofs == OFS_SPECIAL_FUNCTION_CONTROL) begin
      special_function_control_r[PULL_DISABLE_BIT] <= req.wdata[PULL_DISABLE_BIT];
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Port A pin levels; pin registers have no write path at all
  pin_sync #(
    .WIDTH(8)
  ) u_pa_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_level(pa_in),
    .sync_level(pa_sync_r)
  );

  // Port B pin levels, same two stages
  pin_sync #(
    .WIDTH(8)
  ) u_pb_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_level(pb_in),
    .sync_level(pb_sync_r)
  );

  // Port G: second stage gated, so a detached pin never reaches logic
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pg_meta_r <= '0;
      pg_in_sync <= '0;
    end else begin
      pg_meta_r <= pg_in;
      pg_in_sync <= pg_meta_r & pg_input_gate;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Read data registered one cycle after the request; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= acc_rd;
      rdata <= 8'h00;
      if (acc_rd) begin
        case (io_ofs)
          OFS_PORT_A_OUTPUT_LATCH: rdata <= port_a_output_latch_r;
          OFS_PORT_A_DIRECTION: rdata <= port_a_direction_r;
          OFS_PORT_A_PIN_LEVEL: rdata <= pa_sync_r;
          OFS_PORT_B_OUTPUT_LATCH: rdata <= port_b_output_latch_r;
          OFS_PORT_B_DIRECTION: rdata <= port_b_direction_r;
          OFS_PORT_B_PIN_LEVEL: rdata <= pb_sync_r;
          OFS_SPECIAL_FUNCTION_CONTROL: rdata <= special_function_control_r;
          default: rdata <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************************************
  // Ports A and B pad control
  // ****************************************************************
  // Port A pads; no override reaches these pins
  port_pad_ctrl #(
    .WIDTH(8)
  ) u_pa_pads (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .latch(port_a_output_latch_r),
    .direction(port_a_direction_r),
    .pull_disable(pullup_global_disable),
    .pad_out(pa_out),
    .pad_oe(pa_oe),
    .pad_pullup(pa_pullup)
  );

  // Port B pads, same plain behaviour
  port_pad_ctrl #(
    .WIDTH(8)
  ) u_pb_pads (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .latch(port_b_output_latch_r),
    .direction(port_b_direction_r),
    .pull_disable(pullup_global_disable),
    .pad_out(pb_out),
    .pad_oe(pb_oe),
    .pad_pullup(pb_pullup)
  );

  // ****************************************************************
  // Port G override logic
  // ****************************************************************
  logic [PG_WIDTH-1:0] pu_oe, dd_oe, dd_ov, pv_oe, pv_ov, die_oe;
  logic [PG_WIDTH-1:0] g_out, g_oe, g_pu, g_gate;

  // Override tables: oscillator on bits 4/3, memory strobes on bits 2..0
  always_comb begin
    pu_oe = '0;
    dd_oe = '0;
    dd_ov = '0;
    pv_oe = '0;
    pv_ov = '0;
    die_oe = '0;
    pu_oe[PG_XIN_BIT] = async_osc_select;
    dd_oe[PG_XIN_BIT] = async_osc_select;
    die_oe[PG_XIN_BIT] = async_osc_select;
    pu_oe[PG_XOUT_BIT] = async_osc_select;
    dd_oe[PG_XOUT_BIT] = async_osc_select;
    die_oe[PG_XOUT_BIT] = async_osc_select;
    for (int i = PG_WR_BIT; i <= PG_ALE_BIT; i++) begin
      pu_oe[i] = ext_mem_enable;
      dd_oe[i] = ext_mem_enable;
      dd_ov[i] = 1'b1;
      pv_oe[i] = ext_mem_enable;
    end
    pv_ov[PG_ALE_BIT] = ext_mem.ale;
    pv_ov[PG_RD_BIT] = ext_mem.rd_strobe;
    pv_ov[PG_WR_BIT] = ext_mem.wr_strobe;
    // Overridden pull-up value is always zero; override values inactive
    g_oe = (dd_oe & dd_ov) | (~dd_oe & pg_direction);
    g_out = (pv_oe & pv_ov) | (~pv_oe & pg_latch);
    g_pu = ~pu_oe & ~pg_direction & pg_latch & {PG_WIDTH{~pullup_global_disable}};
    g_gate = ~die_oe;
  end

  // Registered Port G pad drive
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pg_out <= '0;
      pg_oe <= '0;
      pg_pullup <= '0;
      pg_input_gate <= '0;
      osc_pins_attached <= 1'b0;
    end else begin
      pg_out <= g_out;
      pg_oe <= g_oe;
      pg_pullup <= g_pu;
      pg_input_gate <= g_gate;
      osc_pins_attached <= async_osc_select;
    end
  end

endmodule : io_port_override_logic

// ****************************************************************
// Two-stage pin synchroniser
// ****************************************************************
// Only the second stage is read outside; the first may go metastable
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin_level,
  output logic [WIDTH-1:0] sync_level
);
  logic [WIDTH-1:0] meta_r;

  // Reset clears both stages so early reads return zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      sync_level <= '0;
    end else begin
      meta_r <= pin_level;
      sync_level <= meta_r;
    end
  end

endmodule : pin_sync

// ****************************************************************
// Plain port pad control
// ****************************************************************
// Costs one cycle of latency but keeps every pad output on a flop
module port_pad_ctrl #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] latch,
  input wire logic [WIDTH-1:0] direction,
  input wire logic pull_disable,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe,
  output logic [WIDTH-1:0] pad_pullup
);

  // Pull-up only on an input with latch one; the global disable wins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pad_out <= '0;
      pad_oe <= '0;
      pad_pullup <= '0;
    end else begin
      pad_out <= latch;
      pad_oe <= direction;
      pad_pullup <= ~direction & latch & {WIDTH{~pull_disable}};
    end
  end

endmodule : port_pad_ctrl

//--- tb/io_port_props.sv
// Checker: port-level assertions for the I/O port block
module io_port_props (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire io_port_pkg::reg_req_s req,
  input wire logic rvalid,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pa_pullup,
  input wire logic async_osc_select,
  input wire logic ext_mem_enable,
  input wire io_port_pkg::ext_mem_s ext_mem,
  input wire logic [4:0] pg_out,
  input wire logic [4:0] pg_oe,
  input wire logic [4:0] pg_pullup,
  input wire logic [4:0] pg_input_gate
);
  timeunit 1ns;
  timeprecision 1ps;
  import io_port_pkg::*;
  // ****
  // Helpers
  // ****
  logic [2:0] strb;
  logic io_op;
  logic data_op;
  assign strb = {ext_mem.ale, ext_mem.rd_strobe, ext_mem.wr_strobe};
  assign io_op = req.io_rd | req.io_wr;
  assign data_op = req.data_load_op | req.mem_save_op;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  AST_XOUT_OFF: assert property (async_osc_select |=> !(pg_oe[3] | pg_pullup[3] | pg_input_gate[3]))
    else $error("osc output pin still used as io");
  AST_XIN_OFF: assert property (async_osc_select |=> !(pg_oe[4] | pg_pullup[4] | pg_input_gate[4]))
    else $error("osc input pin still used as io");
  AST_MEM_FORCE: assert property (ext_mem_enable |=> pg_oe[2:0] == 3'h7 && pg_pullup[2:0] == 3'h0)
    else $error("memory pins not forced out");
  AST_MEM_STRB: assert property (ext_mem_enable |=> pg_out[2:0] == $past(strb))
    else $error("memory strobes not on pins");
  AST_IO_HIT: assert property (req.io_rd && req.addr <= IO_SPACE_LAST |=> rvalid)
    else $error("io access not answered");
  AST_IO_MISS: assert property (io_op && req.addr > IO_SPACE_LAST |=> !rvalid)
    else $error("io access beyond range answered");
  AST_DATA_HIT: assert property (req.data_load_op && req.addr inside {[8'h20:8'h5f]} |=> rvalid)
    else $error("data access not answered");
  AST_DATA_MISS: assert property (data_op && (req.addr < 8'h20 || req.addr >= 8'h60) |=> !rvalid)
    else $error("data access outside window answered");
  AST_PULL_DRV: assert property ((pa_pullup & pa_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  COV_OSC: cover property (async_osc_select ##1 !async_osc_select);
  COV_MEM: cover property (ext_mem_enable ##1 ext_mem_enable);
  COV_READ: cover property (req.data_load_op ##1 rvalid);
endmodule : io_port_props

bind io_port_override_logic io_port_props u_props (.ref_clk, .sys_rst, .req, .rvalid, .pa_oe, .pa_pullup,
  .async_osc_select, .ext_mem_enable, .ext_mem, .pg_out, .pg_oe, .pg_pullup, .pg_input_gate);

//--- tb/ext_side_model.sv
// Partner: external memory strobes and crystal pin levels
module ext_side_model (
  input wire logic ref_clk,
  output io_port_pkg::ext_mem_s ext_mem,
  output logic [4:0] pg_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import io_port_pkg::*;
  logic [2:0] cnt_r = 3'h0;
  // Strobes walk every code so a swapped or stuck bit shows
  always_ff @(posedge ref_clk) begin
    cnt_r <= cnt_r + 3'h1;
  end
  assign ext_mem = ext_mem_s'(cnt_r);
  // Crystal swings in antiphase; low pins echo the strobes
  assign pg_in = {cnt_r[0], ~cnt_r[0], cnt_r};
endmodule : ext_side_model

//--- tb/tb.sv
// Testbench: register, pad and Port G override scenarios
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import io_port_pkg::*;
  localparam logic [3:0] K_IORD = 4'h8, K_IOWR = 4'h4, K_LOAD = 4'h2, K_SAVE = 4'h1;
  logic ref_clk = 1'b0, sys_rst = 1'b1, async_osc_select = 1'b0, ext_mem_enable = 1'b0, rvalid, v;
  reg_req_s req = '0;
  logic [7:0] pa_in = 8'h00, pb_in = 8'h00, rdata, rd, pa_out, pa_oe, pa_pullup, pb_out, pb_oe, pb_pullup;
  logic [4:0] pg_latch = 5'h00, pg_direction = 5'h00, pg_in, pg_out, pg_oe, pg_pullup, pg_input_gate, pg_in_sync;
  logic osc_att;
  ext_mem_s ext_mem, e;
  int error_cnt = 0, check_count = 0;
  io_port_override_logic dut (.ref_clk, .sys_rst, .req, .rdata, .rvalid, .pa_in, .pa_out, .pa_oe, .pa_pullup,
    .pb_in, .pb_out, .pb_oe, .pb_pullup, .async_osc_select, .ext_mem_enable, .ext_mem, .pg_latch, .pg_direction,
    .pg_in, .pg_out, .pg_oe, .pg_pullup, .pg_input_gate, .pg_in_sync, .osc_pins_attached(osc_att));
  ext_side_model u_far (.ref_clk, .ext_mem, .pg_in);
  // ****
  // Tasks
  // ****
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One access, then an idle edge so req is never set twice at once
  task automatic acc(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d);
    req = {k, a, d};
    @(posedge ref_clk);
    #1;
    v = rvalid;
    rd = rdata;
    req = '0;
    @(posedge ref_clk);
    #1;
  endtask : acc
  task automatic rdchk(input logic [3:0] k, input logic [7:0] a, input logic [7:0] exp);
    acc(k, a, 8'h00);
    chk({7'h00, v}, 8'h01);
    chk(rd, exp);
  endtask : rdchk
  task automatic t_reset;
    rdchk(K_IORD, OFS_PORT_A_OUTPUT_LATCH, PORT_RESET);
    rdchk(K_IORD, OFS_PORT_A_DIRECTION, PORT_RESET);
    rdchk(K_IORD, OFS_PORT_A_PIN_LEVEL, 8'h00);
    rdchk(K_IORD, OFS_PORT_B_OUTPUT_LATCH, PORT_RESET);
    rdchk(K_IORD, OFS_PORT_B_DIRECTION, PORT_RESET);
    rdchk(K_LOAD, 8'h40, SFC_RESET);
    chk(pa_oe | pb_oe, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_regs;
    acc(K_IOWR, OFS_PORT_A_DIRECTION, 8'h0f);
    acc(K_SAVE, OFS_PORT_A_OUTPUT_LATCH + DATA_SPACE_BIAS, 8'h33);
    acc(K_IOWR, OFS_PORT_B_DIRECTION, 8'hf0);
    acc(K_IOWR, OFS_PORT_B_OUTPUT_LATCH, 8'h55);
    acc(K_IOWR, OFS_PORT_A_PIN_LEVEL, 8'hff);
    pa_in = 8'h96;
    pb_in = 8'h3c;
    rdchk(K_LOAD, OFS_PORT_A_DIRECTION + DATA_SPACE_BIAS, 8'h0f);
    rdchk(K_IORD, OFS_PORT_A_OUTPUT_LATCH, 8'h33);
    rdchk(K_IORD, OFS_PORT_A_PIN_LEVEL, 8'h96);
    rdchk(K_LOAD, OFS_PORT_B_PIN_LEVEL + DATA_SPACE_BIAS, 8'h3c);
    rdchk(K_IORD, OFS_PORT_B_DIRECTION, 8'hf0);
    rdchk(K_LOAD, OFS_PORT_B_OUTPUT_LATCH + DATA_SPACE_BIAS, 8'h55);
    chk(pa_oe, 8'h0f);
    chk(pa_out, 8'h33);
    chk(pa_pullup, 8'h30);
    chk(pb_out & pb_oe, 8'h50);
    chk(pb_pullup, 8'h05);
    $display("register test done");
  endtask : t_regs
  task automatic t_decode;
    acc(K_IORD, OFS_PORT_A_OUTPUT_LATCH + 8'h40, 8'h00);
    chk({7'h00, v}, 8'h00);
    acc(K_SAVE, EXT_IO_FIRST, 8'hee);
    chk({7'h00, v}, 8'h00);
    acc(K_SAVE, OFS_PORT_A_OUTPUT_LATCH, 8'hee);
    rdchk(K_IORD, OFS_PORT_A_OUTPUT_LATCH, 8'h33);
    $display("decode test done");
  endtask : t_decode
  task automatic t_ovr;
    pg_latch = 5'h1f;
    async_osc_select = 1'b1;
    ext_mem_enable = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({3'h0, pg_oe}, 8'h07);
    chk({3'h0, pg_pullup}, 8'h00);
    chk({3'h0, pg_input_gate}, 8'h07);
    chk({7'h00, osc_att}, 8'h01);
    chk({6'h00, pg_in_sync[4:3]}, 8'h00);
    e = ext_mem;
    @(posedge ref_clk);
    #1;
    chk({5'h00, pg_out[2:0]}, {5'h00, e.ale, e.rd_strobe, e.wr_strobe});
    async_osc_select = 1'b0;
    ext_mem_enable = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({3'h0, pg_pullup}, 8'h1f);
    $display("override test done");
  endtask : t_ovr
  task automatic t_pud;
    acc(K_SAVE, OFS_SPECIAL_FUNCTION_CONTROL + DATA_SPACE_BIAS, 8'hff);
    rdchk(K_IORD, OFS_SPECIAL_FUNCTION_CONTROL, 8'h01 << PULL_DISABLE_BIT);
    chk(pa_pullup | pb_pullup | {3'h0, pg_pullup}, 8'h00);
    acc(K_IOWR, OFS_SPECIAL_FUNCTION_CONTROL, 8'h00);
    chk(pa_pullup, 8'h30);
    $display("pull-up disable test done");
  endtask : t_pud
  task automatic results;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // Run takes about sixty cycles; ten microseconds means a hang
  initial begin
    #10us;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_regs();
    t_decode();
    t_ovr();
    t_pud();
    results();
  end
endmodule : tb
